// file: hw/lvc_map.svh
// register offsets, field positions, reset values and timing figures
// assumes inclusion by the level control top, the monitor and the testbench
`ifndef LVC_MAP_SVH
`define LVC_MAP_SVH

// ----------------------------------------------------------------
// register offsets on the control port
// ----------------------------------------------------------------
`define LVC_ADDR_MODE 7'h7b
`define LVC_ADDR_THRESH_TIMES 7'h7c
`define LVC_ADDR_RESTART_GAIN 7'h7d

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LVC_MODE_RESET 8'h00
`define LVC_THRESH_TIMES_RESET 8'h00
`define LVC_THRESH_TIMES_MASK 8'h7f

// ----------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------
`define LVC_RATE_SELECT_HI 7
`define LVC_RATE_SELECT_LO 6
`define LVC_COUNT_LIMIT_HI 5
`define LVC_COUNT_LIMIT_LO 4
`define LVC_RECOVERY_MODE_HI 3
`define LVC_RECOVERY_MODE_LO 2
`define LVC_DETECT_BOTH_BIT 1
`define LVC_ENABLE_BIT 0

// ----------------------------------------------------------------
// thresholds and times register fields
// ----------------------------------------------------------------
`define LVC_RECOVERY_THRESH_HI 6
`define LVC_RECOVERY_THRESH_LO 5
`define LVC_ATTACK_THRESH_HI 4
`define LVC_ATTACK_THRESH_LO 3
`define LVC_RECOVERY_TIME_HI 2
`define LVC_RECOVERY_TIME_LO 1
`define LVC_ATTACK_TIME_BIT 0

// ----------------------------------------------------------------
// sample rates in khz
// ----------------------------------------------------------------
`define LVC_RATE_96_KHZ 16'd96
`define LVC_RATE_48_KHZ 16'd48
`define LVC_RATE_32_KHZ 16'd32

// ----------------------------------------------------------------
// times in ms
// ----------------------------------------------------------------
`define LVC_ATTACK_TIME_0_MS 16'd1
`define LVC_ATTACK_TIME_1_MS 16'd4
`define LVC_RECOVERY_TIME_0_MS 16'd32
`define LVC_RECOVERY_TIME_1_MS 16'd64
`define LVC_RECOVERY_TIME_2_MS 16'd128
`define LVC_RECOVERY_TIME_3_MS 16'd256

// ----------------------------------------------------------------
// limited recovery counter limits
// ----------------------------------------------------------------
`define LVC_COUNT_LIMIT_0 5'd3
`define LVC_COUNT_LIMIT_1 5'd7
`define LVC_COUNT_LIMIT_2 5'd15
`define LVC_COUNT_LIMIT_3 5'd31

// ----------------------------------------------------------------
// magnitude thresholds, bits 22 to 7 of 24-bit magnitude vs full scale
// ----------------------------------------------------------------
`define LVC_LEVEL_0_DB 16'hffff
`define LVC_LEVEL_M1_DB 16'he429
`define LVC_LEVEL_M2_DB 16'hcb58
`define LVC_LEVEL_M3_DB 16'hb539
`define LVC_LEVEL_M4_DB 16'ha186
`define LVC_LEVEL_M6_DB 16'h804d

// ----------------------------------------------------------------
// gain reduction bounds
// ----------------------------------------------------------------
`define LVC_GAIN_NONE 8'h00
`define LVC_GAIN_MAX 8'hff

`endif

// file: hw/lvc_pkg.sv
// types shared by the level control files
// assumes lvc_map.svh is on the include path
package lvc_pkg;

	typedef enum logic [1:0] {
		LVC_RATE_96K,
		LVC_RATE_48K,
		LVC_RATE_32K,
		LVC_RATE_RSVD
	} lvc_rate_t;

	typedef enum logic [1:0] {
		LVC_REC_NONE,
		LVC_REC_NORMAL,
		LVC_REC_LIMITED,
		LVC_REC_RSVD
	} lvc_rec_mode_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} lvc_reg_req_t;

	typedef struct packed {
		logic [23:0] left;
		logic [23:0] right;
	} lvc_stereo_t;

endpackage : lvc_pkg

// file: hw/lvc_interval_timer.sv
// sample-tick interval timer: pulses once each time its condition has held for target ticks
// assumes tick_in is one clock wide per sample period
`timescale 1ns/100ps
module lvc_interval_timer #(
	parameter int WIDTH = 16
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic clear_in,
	input wire logic run_in,
	input wire logic tick_in,
	input wire logic [WIDTH-1:0] target_in,
	output logic done_out
);
	import lvc_pkg::*;

	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;

	assign next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};

	// ----------------------------------------------------------------
	// counting
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count <= '0;
			done_out <= 1'b0;
		end else if (clear_in || !run_in) begin
			count <= '0;
			done_out <= 1'b0;
		end else if (tick_in) begin
			if (next_count >= target_in) begin
				count <= '0;
				done_out <= 1'b1;
			end else begin
				count <= next_count;
				done_out <= 1'b0;
			end
		end else begin
			done_out <= 1'b0;
		end
	end

endmodule : lvc_interval_timer

// file: hw/lvc_level_control.sv
// level control core: mode and threshold registers, level detect, attack and recovery of gain reduction
// assumes the control port decodes register accesses into one-cycle requests in this clock domain
// assumes one converter sample pair per sample_valid_in pulse
`timescale 1ns/100ps
`include "lvc_map.svh"

module lvc_level_control #(
	parameter int TIMER_WIDTH = 16
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire lvc_pkg::lvc_reg_req_t reg_req_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rvalid_out,
	input wire logic sample_valid_in,
	input wire lvc_pkg::lvc_stereo_t sample_in,
	output logic [7:0] gain_reduction_out,
	output logic limiting_out
);
	import lvc_pkg::*;

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function automatic logic [15:0] magnitude(input logic [23:0] s);
		logic [23:0] m;
		m = s[23] ? (~s + 24'h000001) : s;
		if (m[23]) begin
			magnitude = 16'hffff;
		end else begin
			magnitude = m[22:7];
		end
	endfunction : magnitude

	function automatic logic [15:0] rate_khz(input lvc_rate_t r);
		case (r)
			LVC_RATE_96K: rate_khz = `LVC_RATE_96_KHZ;
			LVC_RATE_48K: rate_khz = `LVC_RATE_48_KHZ;
			LVC_RATE_32K: rate_khz = `LVC_RATE_32_KHZ;
			default: rate_khz = `LVC_RATE_96_KHZ;
		endcase
	endfunction : rate_khz

	function automatic logic [TIMER_WIDTH-1:0] samples(input logic [15:0] ms, input logic [15:0] khz);
		logic [31:0] p;
		p = ms * khz;
		samples = p[TIMER_WIDTH-1:0];
	endfunction : samples

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] level_control_mode;
	logic [7:0] level_control_thresholds_times;
	logic restart;
	logic mode_hit;
	logic thresh_hit;
	logic restart_hit;

	assign mode_hit = (reg_req_in.addr == `LVC_ADDR_MODE);
	assign thresh_hit = (reg_req_in.addr == `LVC_ADDR_THRESH_TIMES);
	assign restart_hit = (reg_req_in.addr == `LVC_ADDR_RESTART_GAIN);

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			level_control_mode <= `LVC_MODE_RESET;
		end else if (reg_req_in.wr && mode_hit) begin
			level_control_mode <= reg_req_in.wdata;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			level_control_thresholds_times <= `LVC_THRESH_TIMES_RESET;
		end else if (reg_req_in.wr && thresh_hit) begin
			level_control_thresholds_times <= reg_req_in.wdata & `LVC_THRESH_TIMES_MASK;
		end
	end

	// write strobe alone restarts, data never looked at
	assign restart = reg_req_in.wr && restart_hit;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= 8'h00;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= reg_req_in.rd;
			if (reg_req_in.rd) begin
				if (mode_hit) begin
					reg_rdata_out <= level_control_mode;
				end else if (thresh_hit) begin
					reg_rdata_out <= level_control_thresholds_times;
				end else if (restart_hit) begin
					reg_rdata_out <= gain_reduction_out;
				end else begin
					reg_rdata_out <= 8'h00;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// field decode
	// ----------------------------------------------------------------
	lvc_rate_t rate_select;
	lvc_rec_mode_t recovery_mode_select;
	logic [1:0] limit_code;
	logic detect_both_channels;
	logic level_control_enable;
	logic [1:0] recovery_threshold;
	logic [1:0] attack_threshold;
	logic [1:0] recovery_time_select;
	logic attack_time_select;

	assign rate_select = lvc_rate_t'(level_control_mode[`LVC_RATE_SELECT_HI:`LVC_RATE_SELECT_LO]);
	assign limit_code = level_control_mode[`LVC_COUNT_LIMIT_HI:`LVC_COUNT_LIMIT_LO];
	assign recovery_mode_select =
		lvc_rec_mode_t'(level_control_mode[`LVC_RECOVERY_MODE_HI:`LVC_RECOVERY_MODE_LO]);
	assign detect_both_channels = level_control_mode[`LVC_DETECT_BOTH_BIT];
	assign level_control_enable = level_control_mode[`LVC_ENABLE_BIT];
	assign recovery_threshold =
		level_control_thresholds_times[`LVC_RECOVERY_THRESH_HI:`LVC_RECOVERY_THRESH_LO];
	assign attack_threshold = level_control_thresholds_times[`LVC_ATTACK_THRESH_HI:`LVC_ATTACK_THRESH_LO];
	assign recovery_time_select =
		level_control_thresholds_times[`LVC_RECOVERY_TIME_HI:`LVC_RECOVERY_TIME_LO];
	assign attack_time_select = level_control_thresholds_times[`LVC_ATTACK_TIME_BIT];

	logic [4:0] limited_recovery_count_limit;
	logic [15:0] attack_level;
	logic [15:0] recovery_level;
	logic [15:0] attack_ms;
	logic [15:0] recovery_ms;

	always_comb begin
		case (limit_code)
			2'b00: limited_recovery_count_limit = `LVC_COUNT_LIMIT_0;
			2'b01: limited_recovery_count_limit = `LVC_COUNT_LIMIT_1;
			2'b10: limited_recovery_count_limit = `LVC_COUNT_LIMIT_2;
			default: limited_recovery_count_limit = `LVC_COUNT_LIMIT_3;
		endcase
	end

	always_comb begin
		case (attack_threshold)
			2'b00: attack_level = `LVC_LEVEL_0_DB;
			2'b01: attack_level = `LVC_LEVEL_M1_DB;
			2'b10: attack_level = `LVC_LEVEL_M2_DB;
			default: attack_level = `LVC_LEVEL_M4_DB;
		endcase
	end

	always_comb begin
		case (recovery_threshold)
			2'b00: recovery_level = `LVC_LEVEL_M2_DB;
			2'b01: recovery_level = `LVC_LEVEL_M3_DB;
			2'b10: recovery_level = `LVC_LEVEL_M4_DB;
			default: recovery_level = `LVC_LEVEL_M6_DB;
		endcase
	end

	always_comb begin
		case (recovery_time_select)
			2'b00: recovery_ms = `LVC_RECOVERY_TIME_0_MS;
			2'b01: recovery_ms = `LVC_RECOVERY_TIME_1_MS;
			2'b10: recovery_ms = `LVC_RECOVERY_TIME_2_MS;
			default: recovery_ms = `LVC_RECOVERY_TIME_3_MS;
		endcase
	end

	assign attack_ms = attack_time_select ? `LVC_ATTACK_TIME_1_MS : `LVC_ATTACK_TIME_0_MS;

	// ----------------------------------------------------------------
	// level detect, captured once per sample
	// ----------------------------------------------------------------
	logic over_attack;
	logic under_recovery;
	logic level_seen;
	logic [15:0] mag_left;
	logic [15:0] mag_right;
	logic left_over;
	logic right_over;

	assign mag_left = magnitude(sample_in.left);
	assign mag_right = magnitude(sample_in.right);
	assign left_over = (mag_left >= attack_level);
	assign right_over = (mag_right >= attack_level);

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			over_attack <= 1'b0;
			under_recovery <= 1'b0;
			level_seen <= 1'b0;
		end else begin
			level_seen <= sample_valid_in;
			if (restart) begin
				over_attack <= 1'b0;
				under_recovery <= 1'b0;
			end else if (sample_valid_in) begin
				// both channels over the limit when detect_both_channels is set, else either one
				if (detect_both_channels) begin
					over_attack <= left_over && right_over;
				end else begin
					over_attack <= left_over || right_over;
				end
				under_recovery <= (mag_left < recovery_level) && (mag_right < recovery_level);
			end
		end
	end

	// ----------------------------------------------------------------
	// attack and recovery timers
	// ----------------------------------------------------------------
	logic attack_done;
	logic recovery_done;
	logic recovery_allowed;
	logic [4:0] recovery_count;
	logic attack_run;
	logic recovery_run;
	logic [TIMER_WIDTH-1:0] attack_target;
	logic [TIMER_WIDTH-1:0] recovery_target;

	always_comb begin
		case (recovery_mode_select)
			LVC_REC_NORMAL: recovery_allowed = 1'b1;
			LVC_REC_LIMITED: recovery_allowed = (recovery_count < limited_recovery_count_limit);
			default: recovery_allowed = 1'b0;
		endcase
	end

	assign attack_run = level_control_enable && over_attack;
	assign recovery_run = level_control_enable && under_recovery && recovery_allowed
		&& (gain_reduction_out != `LVC_GAIN_NONE);
	assign attack_target = samples(attack_ms, rate_khz(rate_select));
	assign recovery_target = samples(recovery_ms, rate_khz(rate_select));

	lvc_interval_timer #(
		.WIDTH(TIMER_WIDTH)
	) u_attack_timer (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.clear_in(restart),
		.run_in(attack_run),
		.tick_in(level_seen),
		.target_in(attack_target),
		.done_out(attack_done)
	);

	lvc_interval_timer #(
		.WIDTH(TIMER_WIDTH)
	) u_recovery_timer (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.clear_in(restart),
		.run_in(recovery_run),
		.tick_in(level_seen),
		.target_in(recovery_target),
		.done_out(recovery_done)
	);

	// ----------------------------------------------------------------
	// gain reduction state
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			gain_reduction_out <= `LVC_GAIN_NONE;
		end else if (restart || !level_control_enable) begin
			gain_reduction_out <= `LVC_GAIN_NONE;
		end else if (attack_done && gain_reduction_out != `LVC_GAIN_MAX) begin
			gain_reduction_out <= gain_reduction_out + 8'h01;
		end else if (recovery_done && recovery_allowed && gain_reduction_out != `LVC_GAIN_NONE) begin
			gain_reduction_out <= gain_reduction_out - 8'h01;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			recovery_count <= 5'd0;
		end else if (restart || !level_control_enable || attack_done) begin
			recovery_count <= 5'd0;
		end else if (recovery_done && recovery_mode_select == LVC_REC_LIMITED && recovery_allowed) begin
			recovery_count <= recovery_count + 5'd1;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			limiting_out <= 1'b0;
		end else begin
			limiting_out <= level_control_enable && !restart && (gain_reduction_out != `LVC_GAIN_NONE);
		end
	end

endmodule : lvc_level_control

// file: verification/lvc_level_control_monitor.sv
// level control checker: port-level timing of reads, restart, enable and gain steps
// assumes binding onto lvc_level_control in one clock domain
`timescale 1ns/100ps
`include "lvc_map.svh"
module lvc_level_control_monitor #(
	parameter int TIMER_WIDTH = 16
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire lvc_pkg::lvc_reg_req_t reg_req_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic reg_rvalid_out,
	input wire logic sample_valid_in,
	input wire lvc_pkg::lvc_stereo_t sample_in,
	input wire logic [7:0] gain_reduction_out,
	input wire logic limiting_out
);
	import lvc_pkg::*;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	// ----------------------------------------
	// shadow of enable and recovery mode
	// ----------------------------------------
	logic en_q;
	logic [1:0] rec_q;
	logic restart;
	logic gain_rd;
	assign restart = reg_req_in.wr && reg_req_in.addr == `LVC_ADDR_RESTART_GAIN;
	assign gain_rd = reg_req_in.rd && reg_req_in.addr == `LVC_ADDR_RESTART_GAIN;
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			en_q <= 1'h0;
			rec_q <= 2'h0;
		end else if (reg_req_in.wr && reg_req_in.addr == `LVC_ADDR_MODE) begin
			en_q <= reg_req_in.wdata[`LVC_ENABLE_BIT];
			rec_q <= reg_req_in.wdata[`LVC_RECOVERY_MODE_HI:`LVC_RECOVERY_MODE_LO];
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_rvalid_idle;
		!reg_req_in.rd |=> !reg_rvalid_out;
	endproperty
	a_rvalid_idle: assert property (p_rvalid_idle) else $error("read valid without read");
	property p_read_gain;
		gain_rd |=> reg_rvalid_out && reg_rdata_out == $past(gain_reduction_out);
	endproperty
	a_read_gain: assert property (p_read_gain) else $error("gain read wrong");
	property p_restart_gain;
		restart |=> gain_reduction_out == 8'h00;
	endproperty
	a_restart_gain: assert property (p_restart_gain) else $error("restart kept gain");
	property p_restart_lim;
		restart |-> ##2 !limiting_out;
	endproperty
	a_restart_lim: assert property (p_restart_lim) else $error("restart kept limiting");
	property p_disabled;
		!en_q && !$past(en_q) |-> gain_reduction_out == 8'h00;
	endproperty
	a_disabled: assert property (p_disabled) else $error("gain while disabled");
	property p_rise_en;
		gain_reduction_out > $past(gain_reduction_out) |-> $past(en_q);
	endproperty
	a_rise_en: assert property (p_rise_en) else $error("gain rose while disabled");
	property p_step;
		$changed(gain_reduction_out) |-> gain_reduction_out == 8'h00
			|| gain_reduction_out - $past(gain_reduction_out) == 8'h01
			|| $past(gain_reduction_out) - gain_reduction_out == 8'h01;
	endproperty
	a_step: assert property (p_step) else $error("gain jumped");
	property p_no_rec;
		(rec_q == 2'h0 || rec_q == 2'h3) && en_q && !restart |=> gain_reduction_out >= $past(gain_reduction_out);
	endproperty
	a_no_rec: assert property (p_no_rec) else $error("recovery in no recovery mode");
	c_restart: cover property (restart && gain_reduction_out != 8'h00);
	c_read: cover property (gain_rd && gain_reduction_out != 8'h00);
	c_limit: cover property (limiting_out ##1 !limiting_out);
endmodule : lvc_level_control_monitor

bind lvc_level_control lvc_level_control_monitor #(.TIMER_WIDTH(TIMER_WIDTH)) u_monitor (
	.mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out),
	.reg_rvalid_out(reg_rvalid_out), .sample_valid_in(sample_valid_in), .sample_in(sample_in),
	.gain_reduction_out(gain_reduction_out), .limiting_out(limiting_out)
);

// file: verification/lvc_testbench.sv
// level control testbench: registers, attack, detect, restart and recovery
// assumes package, map header and design top compiled first
`timescale 1ns/100ps
`include "lvc_map.svh"
module testbench;
	import lvc_pkg::*;
	localparam logic [23:0] LOUD = 24'h7fffff;
	localparam logic [23:0] QUIET = 24'h000000;
	// about -3.25 db, between the -4 and -3 db levels, both signs
	localparam logic [23:0] MID = 24'h580000;
	localparam logic [23:0] MID_NEG = 24'ha80000;
	logic mclk_in = 1'h0;
	logic rst_n_in = 1'h0;
	lvc_reg_req_t reg_req_in = '0;
	logic sample_valid_in = 1'h0;
	lvc_stereo_t sample_in = '0;
	logic [7:0] reg_rdata_out;
	logic [7:0] gain_reduction_out;
	logic reg_rvalid_out;
	logic limiting_out;
	logic [7:0] d;
	int fails = 0;
	int checks_done = 0;
	always #2.5 mclk_in = ~mclk_in;
	lvc_level_control #(.TIMER_WIDTH(16)) dut (
		.mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out),
		.reg_rvalid_out(reg_rvalid_out), .sample_valid_in(sample_valid_in), .sample_in(sample_in),
		.gain_reduction_out(gain_reduction_out), .limiting_out(limiting_out)
	);
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		@(posedge mclk_in);
		reg_req_in <= '{1'h1, 1'h0, a, v};
		@(posedge mclk_in);
		reg_req_in <= '0;
		#1;
	endtask : wr
	task automatic rd(input logic [6:0] a, output logic [7:0] q);
		@(posedge mclk_in);
		reg_req_in <= '{1'h0, 1'h1, a, 8'h00};
		@(posedge mclk_in);
		reg_req_in <= '0;
		#1;
		check({7'h00, reg_rvalid_out}, 8'h01);
		q = reg_rdata_out;
	endtask : rd
	task automatic setup(input logic [7:0] mode, input logic [7:0] thr);
		wr(`LVC_ADDR_MODE, mode);
		wr(`LVC_ADDR_THRESH_TIMES, thr);
		wr(`LVC_ADDR_RESTART_GAIN, 8'h00);
	endtask : setup
	task automatic send(input int n, input logic [23:0] l, input logic [23:0] r);
		repeat (n) begin
			@(posedge mclk_in);
			sample_valid_in <= 1'h1;
			sample_in <= '{l, r};
			@(posedge mclk_in);
			sample_valid_in <= 1'h0;
			repeat (2) @(posedge mclk_in);
		end
		repeat (4) @(posedge mclk_in);
		#1;
	endtask : send
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs;
		for (int i = 0; i < 4; i++) begin
			rd(7'h7a + 7'(i), d);
			check(d, 8'h00);
		end
		wr(`LVC_ADDR_MODE, 8'h36);
		rd(`LVC_ADDR_MODE, d);
		check(d, 8'h36);
		wr(`LVC_ADDR_THRESH_TIMES, 8'hff);
		rd(`LVC_ADDR_THRESH_TIMES, d);
		check(d, 8'h7f);
	endtask : t_regs
	task automatic t_attack;
		int n[3] = '{96, 48, 32};
		for (int i = 0; i < 3; i++) begin
			setup({2'(i), 6'h05}, {3'h0, 2'(i + 1), 3'h0});
			send(n[i] - 1, LOUD, LOUD);
			check(gain_reduction_out, 8'h00);
			send(1, LOUD, LOUD);
			check(gain_reduction_out, 8'h01);
			check({7'h00, limiting_out}, 8'h01);
		end
		setup(8'h85, 8'h19);
		send(127, LOUD, LOUD);
		check(gain_reduction_out, 8'h00);
		send(1, LOUD, LOUD);
		check(gain_reduction_out, 8'h01);
	endtask : t_attack
	task automatic t_detect;
		setup(8'h87, 8'h18);
		send(32, LOUD, QUIET);
		check(gain_reduction_out, 8'h00);
		send(32, LOUD, LOUD);
		check(gain_reduction_out, 8'h01);
		setup(8'h85, 8'h18);
		send(32, QUIET, LOUD);
		check(gain_reduction_out, 8'h01);
	endtask : t_detect
	task automatic t_restart;
		rd(`LVC_ADDR_RESTART_GAIN, d);
		check(d, 8'h01);
		check(gain_reduction_out, 8'h01);
		wr(`LVC_ADDR_RESTART_GAIN, 8'ha5);
		repeat (2) @(posedge mclk_in);
		#1;
		check(gain_reduction_out, 8'h00);
		check({7'h00, limiting_out}, 8'h00);
		send(32, LOUD, LOUD);
		check(gain_reduction_out, 8'h01);
		wr(`LVC_ADDR_MODE, 8'h84);
		repeat (2) @(posedge mclk_in);
		#1;
		check(gain_reduction_out, 8'h00);
		send(32, LOUD, LOUD);
		check(gain_reduction_out, 8'h00);
	endtask : t_restart
	task automatic t_recovery;
		setup(8'h85, 8'h78);
		send(64, LOUD, LOUD);
		check(gain_reduction_out, 8'h02);
		send(1023, QUIET, QUIET);
		check(gain_reduction_out, 8'h02);
		send(1, QUIET, QUIET);
		check(gain_reduction_out, 8'h01);
		setup(8'h81, 8'h3a);
		send(32, LOUD, LOUD);
		send(2048, QUIET, QUIET);
		check(gain_reduction_out, 8'h01);
		setup(8'h89, 8'h58);
		send(160, LOUD, LOUD);
		check(gain_reduction_out, 8'h05);
		send(4096, QUIET, QUIET);
		check(gain_reduction_out, 8'h02);
	endtask : t_recovery
	task automatic t_levels;
		// attack -2 db, recovery -3 db
		setup(8'h85, 8'h30);
		send(32, MID, MID_NEG);
		check(gain_reduction_out, 8'h00);
		send(32, LOUD, LOUD);
		check(gain_reduction_out, 8'h01);
		send(1024, MID, MID_NEG);
		check(gain_reduction_out, 8'h00);
		// attack -2 db, recovery -4 db
		setup(8'h85, 8'h50);
		send(32, LOUD, LOUD);
		send(1024, MID, MID_NEG);
		check(gain_reduction_out, 8'h01);
		// attack -4 db, negative sample on one channel
		setup(8'h85, 8'h18);
		send(32, QUIET, MID_NEG);
		check(gain_reduction_out, 8'h01);
		check({7'h00, limiting_out}, 8'h01);
	endtask : t_levels
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge mclk_in);
		rst_n_in <= 1'h1;
		t_regs();
		t_attack();
		t_detect();
		t_restart();
		t_recovery();
		t_levels();
		give_verdict();
	end
	initial begin
		repeat (100000) @(posedge mclk_in);
		fails++;
		give_verdict();
	end
endmodule : testbench
